// *** src/fcpe_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcpe_top #(
	parameter int MEM_DEPTH      = fcpe_pkg::MEM_DEPTH,
	parameter int REFRESH_CYCLES = fcpe_pkg::REFRESH_CYCLES
) (
	input  wire logic                                   clk,
	input  wire logic                                   arst_n,
	input  wire logic                                   bus_valid,
	input  wire logic                                   bus_src_dmu,
	input  wire logic [fcpe_pkg::DATA_W-1:0]            bus_data,
	input  wire logic [fcpe_pkg::BYTES-1:0]             bus_par,
	input  wire logic                                   dmu_valid,
	input  wire logic [fcpe_pkg::DATA_W-1:0]            dmu0_result,
	input  wire logic [fcpe_pkg::DATA_W-1:0]            dmu1_result,
	output logic      [fcpe_pkg::DATA_W-1:0]            dmu_out_data,
	output logic      [fcpe_pkg::BYTES-1:0]             dmu_out_par,
	input  wire logic                                   ucode_valid,
	input  wire logic [fcpe_pkg::UCODE_W-1:0]           ucode_ctrl,
	input  wire logic [fcpe_pkg::UCODE_CHK_W-1:0]       ucode_chk,
	input  wire logic                                   periph_err_report,
	input  wire logic                                   mem_req,
	input  wire logic                                   mem_we,
	input  wire logic [$clog2(MEM_DEPTH)-1:0]           mem_addr,
	input  wire logic [fcpe_pkg::DATA_W-1:0]            mem_wdata,
	input  wire logic [fcpe_pkg::CW_W-1:0]              mem_inject,
	output logic                                        mem_ready,
	output logic                                        mem_rvalid,
	output logic      [fcpe_pkg::DATA_W-1:0]            mem_rdata,
	input  wire logic [fcpe_pkg::NERR-1:0]              err_clear,
	input  wire logic                                   cap_clear,
	output logic      [fcpe_pkg::NERR-1:0]              err_pending,
	output logic                                        microint,
	output logic                                        hard_switch,
	output logic                                        cap_valid,
	output logic                                        cap_multi,
	output logic      [$clog2(MEM_DEPTH)-1:0]           cap_addr,
	output logic      [fcpe_pkg::CHK_W-1:0]             cap_syndrome,
	output logic      [$clog2(MEM_DEPTH)-1:0]           scrub_addr
);
	import fcpe_pkg::*;
	localparam int ADDR_W = $clog2(MEM_DEPTH);
	localparam int CNT_W  = $clog2(REFRESH_CYCLES + 1);

	generate
		if (MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
			$error("MEM_DEPTH must be a power of two, at least 2");
		if (REFRESH_CYCLES < 4)
			$error("REFRESH_CYCLES must be at least 4");
	endgenerate

	logic                     cap_bus_valid_reg;
	logic                     cap_bus_dmu_reg;
	logic [DATA_W-1:0]        cap_bus_data_reg;
	logic [BYTES-1:0]         cap_bus_par_reg;
	logic [DATA_W-1:0]        dmu_out_data_reg;
	logic [BYTES-1:0]         dmu_out_par_reg;
	logic                     ucode_bad;
	logic                     match_bad;
	logic [CNT_W-1:0]         refresh_cnt_reg;
	logic                     scrub_due_reg;
	logic [ADDR_W-1:0]        scrub_addr_reg;
	fcpe_mstate_type          mem_state_reg;
	fcpe_mstate_type          mem_state_next;
	logic                     mem_ready_reg;
	logic                     mem_rvalid_reg;
	logic [DATA_W-1:0]        mem_rdata_reg;
	logic [CW_W-1:0]          rd_cw_reg;
	logic [ADDR_W-1:0]        rd_addr_reg;
	logic [CW_W-1:0]          mem_array [MEM_DEPTH];
	logic                     take_read;
	logic                     take_write;
	logic                     scrub_start;
	logic                     rd_check;
	logic [DATA_W-1:0]        dec_data;
	logic [CHK_W-1:0]         dec_syndrome;
	logic                     dec_single;
	logic                     dec_multi;
	logic                     ev_sb;
	logic                     ev_mb;
	logic [NERR-1:0]          err_ev;
	logic [NERR-1:0]          err_pending_reg;
	logic [NERR-1:0]          err_pending_next;
	logic [NERR-1:0]          held_err;
	logic                     microint_reg;
	logic                     hard_switch_reg;
	logic                     cap_valid_reg;
	logic                     cap_multi_reg;
	logic [ADDR_W-1:0]        cap_addr_reg;
	logic [CHK_W-1:0]         cap_syndrome_reg;

	// bus trap: the transfer itself is untouched, the copy is checked a cycle later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_bus_valid_reg <= 1'h0;
			cap_bus_dmu_reg   <= 1'h0;
			cap_bus_data_reg  <= '0;
			cap_bus_par_reg   <= '0;
		end else begin
			cap_bus_valid_reg <= bus_valid;
			cap_bus_dmu_reg   <= bus_src_dmu;
			cap_bus_data_reg  <= bus_data;
			cap_bus_par_reg   <= bus_par;
		end
	end
	// no port for destination loads: a loaded register is checked when it next
	// drives the bus, so a stale bad byte is still caught, one cycle after it is used

	fcpe_chk_if chk_bus ();
	assign chk_bus.valid   = cap_bus_valid_reg;
	assign chk_bus.src_dmu = cap_bus_dmu_reg;
	assign chk_bus.data    = cap_bus_data_reg;
	assign chk_bus.par     = cap_bus_par_reg;

	fcpe_par_chk u_par_chk (
		.port (chk_bus.chk)
	);

	// data from one half, parity from the other, so a fault in either half
	// shows as a parity error downstream
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dmu_out_data_reg <= '0;
			dmu_out_par_reg  <= '0;
		end else if (dmu_valid) begin
			dmu_out_data_reg <= dmu0_result;
			dmu_out_par_reg  <= fcpe_byte_par(dmu1_result);
		end
	end
	assign dmu_out_data = dmu_out_data_reg;
	assign dmu_out_par  = dmu_out_par_reg;

	assign match_bad = dmu_valid && (dmu0_result != dmu1_result);

	always_comb begin
		ucode_bad = 1'h0;
		for (int i = 0; i < UCODE_CHK_W; i++)
			ucode_bad = ucode_bad | (ucode_chk[i] != fcpe_par8(ucode_ctrl[8*i +: 8]));
		ucode_bad = ucode_bad & ucode_valid;
	end

	// refresh divider: one scrub per interval, so a full pass takes
	// MEM_DEPTH intervals and grows with the installed capacity
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			refresh_cnt_reg <= '0;
			scrub_due_reg   <= 1'h0;
		end else begin
			if (refresh_cnt_reg == CNT_W'(REFRESH_CYCLES - 1)) begin
				refresh_cnt_reg <= '0;
				scrub_due_reg   <= 1'h1;
			end else begin
				refresh_cnt_reg <= refresh_cnt_reg + CNT_W'(1);
				if (scrub_start) scrub_due_reg <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) scrub_addr_reg <= '0;
		else if (mem_state_reg == FCPE_SREAD) scrub_addr_reg <= scrub_addr_reg + ADDR_W'(1);
	end

	// host access wins over scrubbing; a due scrub waits for an idle cycle
	assign take_write  = mem_ready_reg && mem_req && mem_we;
	assign take_read   = mem_ready_reg && mem_req && !mem_we;
	assign scrub_start = mem_ready_reg && !mem_req && scrub_due_reg;
	assign rd_check    = (mem_state_reg == FCPE_HREAD) || (mem_state_reg == FCPE_SREAD);

	always_comb begin
		mem_state_next = mem_state_reg;
		unique case (mem_state_reg)
			FCPE_IDLE: begin
				if (take_read) mem_state_next = FCPE_HREAD;
				else if (scrub_start) mem_state_next = FCPE_SREAD;
			end
			FCPE_HREAD: mem_state_next = FCPE_IDLE;
			FCPE_SREAD: mem_state_next = FCPE_IDLE;
			default: mem_state_next = FCPE_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_state_reg <= FCPE_IDLE;
			mem_ready_reg <= 1'h1;
		end else begin
			mem_state_reg <= mem_state_next;
			mem_ready_reg <= (mem_state_next == FCPE_IDLE);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_cw_reg   <= '0;
			rd_addr_reg <= '0;
		end else if (take_read) begin
			rd_cw_reg   <= mem_array[mem_addr];
			rd_addr_reg <= mem_addr;
		end else if (scrub_start) begin
			rd_cw_reg   <= mem_array[scrub_addr_reg];
			rd_addr_reg <= scrub_addr_reg;
		end
	end

	// the array is storage only and has no reset; mem_inject lets a test plant
	// bit errors in the stored code word
	always_ff @(posedge clk) begin
		if (take_write)
			mem_array[mem_addr] <= fcpe_ecc_encode(mem_wdata) ^ mem_inject;
		else if (mem_state_reg == FCPE_SREAD && dec_single)
			mem_array[rd_addr_reg] <= fcpe_ecc_encode(dec_data);
	end

	fcpe_secded u_secded (
		.cw       (rd_cw_reg),
		.data     (dec_data),
		.syndrome (dec_syndrome),
		.single   (dec_single),
		.multi    (dec_multi)
	);

	// every read goes through the decoder, corrected data is what returns
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_rvalid_reg <= 1'h0;
			mem_rdata_reg  <= '0;
		end else begin
			mem_rvalid_reg <= (mem_state_reg == FCPE_HREAD);
			if (mem_state_reg == FCPE_HREAD) mem_rdata_reg <= dec_data;
		end
	end
	assign mem_ready  = mem_ready_reg;
	assign mem_rvalid = mem_rvalid_reg;
	assign mem_rdata  = mem_rdata_reg;

	assign ev_sb = rd_check && dec_single;
	assign ev_mb = rd_check && dec_multi;

	always_comb begin
		err_ev             = '0;
		err_ev[ERR_SRC]    = chk_bus.err_src;
		err_ev[ERR_DMU]    = chk_bus.err_dmu;
		err_ev[ERR_UCODE]  = ucode_bad;
		err_ev[ERR_MATCH]  = match_bad;
		err_ev[ERR_MEM_SB] = ev_sb;
		err_ev[ERR_MEM_MB] = ev_mb;
		err_ev[ERR_PERIPH] = periph_err_report;
	end

	// a new event wins over a clear in the same cycle so nothing is dropped
	assign held_err         = err_pending_reg & ~err_clear;
	assign err_pending_next = held_err | err_ev;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			err_pending_reg <= ERR_PEND_RST;
			microint_reg    <= 1'h0;
		end else begin
			err_pending_reg <= err_pending_next;
			microint_reg    <= |(err_pending_next & LESS_MASK);
		end
	end

	// a hard switch cannot be undone from this side; only reset drops it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) hard_switch_reg <= 1'h0;
		else if (|(err_ev & SEVERE_MASK)) hard_switch_reg <= 1'h1;
	end

	// the first error stays logged; only a multi-bit error may replace a single
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_valid_reg    <= 1'h0;
			cap_multi_reg    <= 1'h0;
			cap_addr_reg     <= '0;
			cap_syndrome_reg <= '0;
		end else if ((ev_sb || ev_mb) && (!cap_valid_reg || (ev_mb && !cap_multi_reg))) begin
			cap_valid_reg    <= 1'h1;
			cap_multi_reg    <= ev_mb;
			cap_addr_reg     <= rd_addr_reg;
			cap_syndrome_reg <= dec_syndrome;
		end else if (cap_clear) begin
			cap_valid_reg    <= 1'h0;
			cap_multi_reg    <= 1'h0;
		end
	end

	assign err_pending  = err_pending_reg;
	assign microint     = microint_reg;
	assign hard_switch  = hard_switch_reg;
	assign cap_valid    = cap_valid_reg;
	assign cap_multi    = cap_multi_reg;
	assign cap_addr     = cap_addr_reg;
	assign cap_syndrome = cap_syndrome_reg;
	assign scrub_addr   = scrub_addr_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_read_taken;
		mem_req && !mem_we && mem_ready_reg;
	endsequence
	sequence s_scrub_read;
		mem_state_reg == FCPE_SREAD;
	endsequence

	a_src_bus_par: assert property (
		bus_valid && !bus_src_dmu && (bus_par != fcpe_byte_par(bus_data))
		|-> ##2 err_pending_reg[ERR_SRC])
		else $error("source bus parity error not flagged");
	a_dmu_unit_par: assert property (
		bus_valid && bus_src_dmu && (bus_par != fcpe_byte_par(bus_data))
		|-> ##2 (err_pending_reg[ERR_DMU] && microint_reg))
		else $error("arithmetic unit parity error not flagged");
	a_dmu_split_out: assert property (
		dmu_valid |=> (dmu_out_data_reg == $past(dmu0_result))
		&& (dmu_out_par_reg == fcpe_byte_par($past(dmu1_result))))
		else $error("arithmetic output not split between halves");
	a_ucode_par_err: assert property (
		ucode_valid && ((ucode_chk[3:0] != fcpe_byte_par(ucode_ctrl[31:0]))
		|| (ucode_chk[7:4] != fcpe_byte_par(ucode_ctrl[63:32])))
		|=> err_pending_reg[ERR_UCODE] && hard_switch_reg)
		else $error("microcontrol parity error not raised");
	a_match_hard_switch: assert property (
		dmu_valid && (dmu0_result != dmu1_result)
		|=> hard_switch_reg [*3])
		else $error("matcher mismatch did not hold hard switch");
	a_read_checked: assert property (
		s_read_taken |-> ##1 !mem_ready_reg ##1 (mem_rvalid_reg && mem_ready_reg))
		else $error("read not answered after checking");
	a_single_corrected: assert property (
		mem_state_reg == FCPE_HREAD && dec_single
		|=> mem_rvalid_reg && (mem_rdata_reg == $past(dec_data)) && err_pending_reg[ERR_MEM_SB])
		else $error("single bit error not corrected and logged");
	a_multi_logged: assert property (
		rd_check && dec_multi |=> err_pending_reg[ERR_MEM_MB] && cap_valid_reg && cap_multi_reg)
		else $error("multi bit error not captured");
	a_scrub_step: assert property (
		s_scrub_read |=> (scrub_addr_reg == $past(scrub_addr_reg) + ADDR_W'(1))
		&& (mem_state_reg == FCPE_IDLE))
		else $error("scrub did not advance");
	a_scrub_start: assert property (
		scrub_due_reg && mem_state_reg == FCPE_IDLE && !mem_req |=> s_scrub_read)
		else $error("due scrub not started");
	a_pending_hold: assert property (
		1'h1 |=> ((err_pending_reg & $past(held_err)) == $past(held_err)))
		else $error("pending error lost without clear");
	a_less_microint: assert property (
		$rose(err_pending_reg[ERR_MEM_SB]) && !$past(hard_switch_reg)
		|-> microint_reg && !hard_switch_reg)
		else $error("less severe error switched or no microinterrupt");
	a_capture_addr: assert property (
		rd_check && (dec_single || dec_multi) && !cap_valid_reg
		|=> cap_addr_reg == $past(rd_addr_reg))
		else $error("failing address not captured");
endmodule : fcpe_top
`default_nettype wire

// *** src/fcpe_pkg.sv ***
// Summary of operation
// - every byte on the internal buses carries its own parity bit
// - bus word is trapped and parity checked in the next cycle, no added delay
// - destination loads are not checked; data is checked when later used as source
// - arithmetic unit is duplicated: one half gives data, other half gives parity
// - arithmetic result leaving onto the bus gets its own distinct parity error
// - microstore words carry check bits; a bad fetched control word flags an error
// - memory words use a Hamming code; single-bit errors are corrected transparently
// - every word read from memory is checked
// - refresh scrubbing steps through all locations, period scales with capacity
// - memory detects, without correcting, most errors of two or more bits
// - corrected and uncorrectable memory errors are logged and raise a microinterrupt
// - memory error and status details are visible to recovery software
// - parity on every bus plus matchers on duplicated logic detect faults
// - every detector event records an error interrupt; peripherals send a report
// - the most severe error classes start a hard switch to the mate processor
// - less severe errors raise a microinterrupt instead of switching
package fcpe_pkg;
	localparam int               DATA_W         = 32;
	localparam int               BYTES          = DATA_W / 8;
	localparam int               CHK_W          = 6;
	localparam int               CW_W           = DATA_W + CHK_W + 1;
	localparam int               UCODE_W        = 64;
	localparam int               UCODE_CHK_W    = UCODE_W / 8;
	localparam logic             PAR_ODD        = 1'h1;
	localparam int               MEM_DEPTH      = 1024;
	localparam int               CLK_PERIOD_PS  = 5000;
	localparam int               REFRESH_NS     = 7800;
	localparam int               REFRESH_CYCLES = (REFRESH_NS * 1000) / CLK_PERIOD_PS;
	localparam int               NERR           = 7;
	localparam int               ERR_SRC        = 0;
	localparam int               ERR_DMU        = 1;
	localparam int               ERR_UCODE      = 2;
	localparam int               ERR_MATCH      = 3;
	localparam int               ERR_MEM_SB     = 4;
	localparam int               ERR_MEM_MB     = 5;
	localparam int               ERR_PERIPH     = 6;
	localparam logic [NERR-1:0]  SEVERE_MASK    = 7'h0C;
	localparam logic [NERR-1:0]  LESS_MASK      = 7'h73;
	localparam logic [NERR-1:0]  ERR_PEND_RST   = 7'h00;

	typedef enum logic [1:0] {
		FCPE_IDLE  = 2'b00,
		FCPE_HREAD = 2'b01,
		FCPE_SREAD = 2'b10
	} fcpe_mstate_type;

	// odd parity: the bit makes the count of ones in byte plus bit odd
	function automatic logic fcpe_par8(input logic [7:0] b);
		return (^b) ^ PAR_ODD;
	endfunction : fcpe_par8

	function automatic logic [BYTES-1:0] fcpe_byte_par(input logic [DATA_W-1:0] d);
		logic [BYTES-1:0] p;
		p = '0;
		for (int i = 0; i < BYTES; i++) p[i] = fcpe_par8(d[8*i +: 8]);
		return p;
	endfunction : fcpe_byte_par

	// check bits at power-of-two positions, overall parity in bit 0
	function automatic logic [CW_W-1:0] fcpe_ecc_encode(input logic [DATA_W-1:0] d);
		logic [CW_W-1:0]  cw;
		logic [CHK_W-1:0] syn;
		int               k;
		cw  = '0;
		syn = '0;
		k   = 0;
		for (int i = 1; i < CW_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				cw[i] = d[k];
				k++;
			end
		end
		for (int i = 1; i < CW_W; i++) if (cw[i]) syn = syn ^ CHK_W'(i);
		for (int p = 0; p < CHK_W; p++) cw[1 << p] = syn[p];
		cw[0] = ^cw[CW_W-1:1];
		return cw;
	endfunction : fcpe_ecc_encode
endpackage : fcpe_pkg

// *** src/fcpe_chk_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fcpe_chk_if;
	import fcpe_pkg::*;
	logic              valid;
	logic              src_dmu;
	logic [DATA_W-1:0] data;
	logic [BYTES-1:0]  par;
	logic              err_src;
	logic              err_dmu;
	modport src (output valid, output src_dmu, output data, output par,
		input err_src, input err_dmu);
	modport chk (input valid, input src_dmu, input data, input par,
		output err_src, output err_dmu);
endinterface : fcpe_chk_if
`default_nettype wire

// *** src/fcpe_par_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcpe_par_chk (
	fcpe_chk_if.chk port
);
	import fcpe_pkg::*;
	logic bad;
	assign bad          = port.par != fcpe_byte_par(port.data);
	assign port.err_src = port.valid && !port.src_dmu && bad;
	assign port.err_dmu = port.valid && port.src_dmu && bad;
endmodule : fcpe_par_chk
`default_nettype wire

// *** src/fcpe_secded.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcpe_secded (
	input  wire logic [fcpe_pkg::CW_W-1:0]   cw,
	output logic      [fcpe_pkg::DATA_W-1:0] data,
	output logic      [fcpe_pkg::CHK_W-1:0]  syndrome,
	output logic                             single,
	output logic                             multi
);
	import fcpe_pkg::*;
	logic [CW_W-1:0] fixed;
	logic            ovr;

	always_comb begin
		int k;
		k        = 0;
		syndrome = '0;
		for (int i = 1; i < CW_W; i++) if (cw[i]) syndrome = syndrome ^ CHK_W'(i);
		ovr = ^cw;
		// odd overall parity with a syndrome in range is one flipped bit
		single = ovr && (int'(syndrome) < CW_W);
		// even overall parity with a nonzero syndrome means two or more bits
		multi  = (!ovr && syndrome != '0) || (ovr && int'(syndrome) >= CW_W);
		fixed  = cw;
		if (single) fixed[syndrome] = ~cw[syndrome];
		data = '0;
		for (int i = 1; i < CW_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				data[k] = fixed[i];
				k++;
			end
		end
	end
endmodule : fcpe_secded
`default_nettype wire

// *** tb/fcpe_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcpe_bus_model (
	input  wire logic                         clk,
	output logic                              bus_valid,
	output logic                              bus_src_dmu,
	output logic      [fcpe_pkg::DATA_W-1:0]  bus_data,
	output logic      [fcpe_pkg::BYTES-1:0]   bus_par
);
	import fcpe_pkg::*;
	initial begin
		{bus_valid, bus_src_dmu, bus_data, bus_par} = '0;
	end
	// one bus word per call; bad flips the check bit of the marked bytes
	task automatic put(input logic [DATA_W-1:0] d, input logic [BYTES-1:0] bad, input logic data_manipulation_unit);
		@(posedge clk);
		#1;
		bus_valid   = 1'b1;
		bus_src_dmu = data_manipulation_unit;
		bus_data    = d;
		for (int i = 0; i < BYTES; i++) bus_par[i] = ~^d[8*i +: 8] ^ bad[i];
		@(posedge clk);
		#1;
		bus_valid = 1'b0;
		// released bus shows inverted values so a stale word can never look valid
		bus_data  = ~d;
		bus_par   = ~bus_par;
	endtask : put
endmodule : fcpe_bus_model
`default_nettype wire

// *** tb/fault_check_parity_ecc_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module fault_check_parity_ecc_bench;
	import fcpe_pkg::*;
	logic              clk = 1'b0;
	logic              arst_n, bus_valid, bus_src_dmu, dmu_valid, ucode_valid, periph_err_report;
	logic              mem_req, mem_we, mem_ready, mem_rvalid, cap_clear;
	logic              microint, hard_switch, cap_valid, cap_multi;
	logic [DATA_W-1:0] bus_data, dmu0_result, dmu1_result, dmu_out_data, mem_wdata, mem_rdata;
	logic [BYTES-1:0]  bus_par, dmu_out_par;
	logic [63:0]       ucode_ctrl;
	logic [7:0]        ucode_chk;
	logic [2:0]        mem_addr, cap_addr, scrub_addr;
	logic [CW_W-1:0]   mem_inject;
	logic [CHK_W-1:0]  cap_syndrome;
	logic [NERR-1:0]   err_clear, err_pending;
	int                fails = 0;
	int                compares = 0;

	fcpe_bus_model i_bus (.clk, .bus_valid, .bus_src_dmu, .bus_data, .bus_par);
	// short memory and refresh interval keep a full scrub sweep within a few dozen cycles
	fcpe_top #(.MEM_DEPTH(8), .REFRESH_CYCLES(6)) i_dut (.clk, .arst_n, .bus_valid, .bus_src_dmu,
		.bus_data, .bus_par, .dmu_valid, .dmu0_result, .dmu1_result, .dmu_out_data, .dmu_out_par,
		.ucode_valid, .ucode_ctrl, .ucode_chk, .periph_err_report, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_inject, .mem_ready, .mem_rvalid, .mem_rdata, .err_clear, .cap_clear,
		.err_pending, .microint, .hard_switch, .cap_valid, .cap_multi, .cap_addr,
		.cap_syndrome, .scrub_addr);

	always #2.5 clk = ~clk;

	function automatic logic [7:0] opar(input logic [63:0] d);
		for (int i = 0; i < 8; i++) opar[i] = ~^d[8*i +: 8];
	endfunction : opar

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic rst;
		arst_n = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		arst_n = 1'b1;
	endtask : rst

	task automatic clr;
		mem_req   = 1'b0;
		err_clear = '1;
		cap_clear = 1'b1;
		tick(1);
		err_clear = '0;
		cap_clear = 1'b0;
	endtask : clr

	task automatic wr(input logic [2:0] a, input logic [CW_W-1:0] inj);
		while (mem_ready !== 1'b1) tick(1);
		{mem_req, mem_we, mem_addr, mem_inject} = {2'b11, a, inj};
		mem_wdata = 32'hC0DE_0000 + a;
		// request stays up so back-to-back writes never toggle it in one step;
		// the next read or clr drops it
		tick(1);
	endtask : wr

	task automatic rd(input logic [2:0] a);
		while (mem_ready !== 1'b1) tick(1);
		{mem_req, mem_we, mem_addr} = {2'b10, a};
		tick(1);
		mem_req = 1'b0;
		check(mem_ready, 1'b0);
		tick(1);
		check({mem_rvalid, mem_ready}, 2'b11);
	endtask : rd

	task automatic t_mem;
		for (int a = 0; a < 8; a++) wr(3'(a), (a == 3) ? 39'h8 : 39'h0);
		rd(3'h0);
		check(mem_rdata, 32'hC0DE_0000);
		check(err_pending, 7'h00);
		rd(3'h3);
		check(mem_rdata, 32'hC0DE_0003);
		check(err_pending, 7'h10);
		check({microint, cap_valid, cap_multi, cap_addr}, 6'h33);
		check(cap_syndrome, 6'h03);
		clr();
		repeat (120) if (err_pending[4] !== 1'b1) tick(1);
		check({err_pending, cap_addr}, 10'h083);
		check(scrub_addr, 3'h4);
		clr();
		tick(100);
		check(err_pending, 7'h00);
		wr(3'h5, 39'h28);
		rd(3'h5);
		check(err_pending, 7'h20);
		check({cap_valid, cap_multi, cap_addr}, 5'h1D);
		check(cap_syndrome, 6'h06);
		wr(3'h5, '0);
		clr();
		$display("memory test done");
	endtask : t_mem

	task automatic t_bus;
		i_bus.put(32'h5A5A_0FF0, 4'h0, 1'b0);
		tick(3);
		check(err_pending, 7'h00);
		for (int b = 0; b < BYTES; b++) begin
			i_bus.put(32'h1357_9BDF, 4'(1 << b), b[0]);
			tick(5);
			check(err_pending, 7'(1 << b[0]));
			check({microint, hard_switch}, 2'b10);
			clr();
			tick(1);
			check(err_pending, 7'h00);
		end
		periph_err_report = 1'b1;
		tick(1);
		periph_err_report = 1'b0;
		tick(2);
		check({err_pending, microint, hard_switch}, 9'h102);
		clr();
		$display("bus parity test done");
	endtask : t_bus

	task automatic t_dup;
		{dmu_valid, dmu0_result, dmu1_result} = {1'b1, 32'h0102_80FF, 32'h0102_80FF};
		tick(1);
		check({dmu_out_data, dmu_out_par}, {32'h0102_80FF, 4'(opar(32'h0102_80FF))});
		check(hard_switch, 1'b0);
		dmu1_result = 32'h0103_80FF;
		tick(1);
		dmu_valid = 1'b0;
		check({dmu_out_data, dmu_out_par}, {32'h0102_80FF, 4'(opar(32'h0103_80FF))});
		tick(4);
		check({err_pending, microint, hard_switch}, 9'h021);
		rst();
		{ucode_valid, ucode_ctrl} = {1'b1, 64'h0011_2233_4455_6677};
		ucode_chk = opar(ucode_ctrl);
		tick(1);
		check({err_pending, hard_switch}, 8'h00);
		ucode_chk = ucode_chk ^ 8'h10;
		tick(1);
		ucode_valid = 1'b0;
		tick(2);
		check({err_pending, microint, hard_switch}, 9'h011);
		$display("duplicate and microstore test done");
	endtask : t_dup

	initial begin
		{arst_n, dmu_valid, ucode_valid, periph_err_report, mem_req, mem_we, cap_clear} = '0;
		{dmu0_result, dmu1_result, ucode_ctrl, ucode_chk, mem_addr, mem_wdata, mem_inject} = '0;
		err_clear = '0;
		rst();
		t_mem();
		t_bus();
		t_dup();
		conclude();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#40000;
		fails++;
		$display("watchdog expired");
		conclude();
	end
endmodule : fault_check_parity_ecc_bench
`default_nettype wire
